// ==== acs_pkg.sv ====
/*
  Shared constants of the converter control and status sequencer: register
  offsets, control field positions, reset values and conversion lengths.
  Assumes one 10 MHz clock, where one converter state is one clock period.
*/
package acs_pkg;

  // ==========================================================
  // register map
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 8;
  localparam logic [3:0]  OFS_RES_BASE = 4'h0;  // result words A..D, high byte first
  localparam logic [3:0]  OFS_CSR      = 4'h8;
  localparam logic [3:0]  OFS_IRQ_STAT = 4'h9;
  localparam logic [3:0]  OFS_IRQ_MASK = 4'hA;

  // ==========================================================
  // control/status fields
  localparam int          BIT_DONE     = 7;
  localparam int          BIT_IE       = 6;
  localparam int          BIT_GO       = 5;
  localparam int          BIT_SCAN     = 4;
  localparam int          BIT_SPEED    = 3;
  localparam int          CHAN_MSB     = 2;
  localparam logic [7:0]  CSR_RESET    = 8'h00;

  // ==========================================================
  // interrupt status bits
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_PASS     = 0;  // end flag raised
  localparam int          IRQ_STORE    = 1;  // any result stored
  localparam logic [1:0]  IRQ_RESET    = 2'h0;

  // ==========================================================
  // result layout and timing
  localparam int          RES_W        = 10;
  localparam int          RES_PAD      = 6;
  localparam logic [15:0] RES_RESET    = 16'h0000;
  localparam int          CLK_NS       = 100;
  localparam int          STATE_NS     = 100;
  localparam int          CONV_SLOW_STATES = 134;
  localparam int          CONV_FAST_STATES = 70;
  localparam logic [7:0]  CONV_SLOW_CYC = 8'(CONV_SLOW_STATES * STATE_NS / CLK_NS);
  localparam logic [7:0]  CONV_FAST_CYC = 8'(CONV_FAST_STATES * STATE_NS / CLK_NS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } acs_state_e;

endpackage

// ==== acs_result_mem.sv ====
/*
  Four 16-bit result words with a registered byte read port.
  Assumes the owner gives bytes for non-result offsets already decoded.
*/
module acs_result_mem
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // write side
  input  wire logic                wr_en,
  input  wire logic [1:0]          wr_idx,
  input  wire logic [15:0]         wr_data,
  // read side
  input  wire logic                rd_en,
  input  wire logic [ADDR_W-1:0]   rd_addr,
  input  wire logic [DATA_W-1:0]   reg_byte,
  output logic      [DATA_W-1:0]   rd_data_r
);
  import acs_pkg::*;

  logic [15:0] word_r [4];

  // ==========================================================
  // storage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        word_r[i] <= RES_RESET;
      end
    end else if (wr_en) begin
      word_r[wr_idx] <= wr_data;
    end
  end

  // ==========================================================
  // read port; data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (!rd_en) begin
      rd_data_r <= 8'h00;
    end else if (rd_addr[3] == OFS_RES_BASE[3]) begin
      rd_data_r <= rd_addr[0] ? word_r[rd_addr[2:1]][7:0] : word_r[rd_addr[2:1]][15:8];
    end else begin
      rd_data_r <= reg_byte;
    end
  end

endmodule

// ==== acs_sequencer.sv ====
/*
  Control/status register and conversion sequencer of an eight-input 10-bit
  converter, with result store and interrupt status.
  Assumes the analog core presents its finished code on sar_data at the end
  of each conversion period, on the same clock.
*/
// Behaviour
// - single mode: end flag sets when the chosen channel finishes
// - sweep mode: end flag sets after each full pass over selected channels
// - end flag clears only on a 0 write after reading it as 1
// - writing 1 to the go bit starts conversion with current settings
// - single mode: go bit clears itself when the conversion completes
// - sweep mode: keeps converting until go cleared, reset or standby
// - mode bit: 0 single conversion, 1 group sweep
// - speed bit: 0 gives 134 states, 1 gives 70 states
// - single mode: channel code 0..7 selects input 0..7
// - sweep: top bit picks group, low bits give channel count minus one
// - end flag with interrupt enable raises the conversion-end interrupt
// - result stored left-justified in bits 15..6, low six bits zero
// - inputs n and n+4 share result word n
// - sweep restarts at the first channel of the group after a pass
module acs_sequencer
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // register port
  input  wire logic [acs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [acs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [acs_pkg::DATA_W-1:0] reg_rdata,
  // analog core
  input  wire logic [acs_pkg::RES_W-1:0]  sar_data,
  output logic      [2:0]                 sar_channel_r,
  output logic                            sar_busy_r,
  output logic                            sar_fast_r,
  // system
  input  wire logic                       standby_req,
  output logic                            conversion_end_irq_r
);
  import acs_pkg::*;

  // ==========================================================
  // state
  acs_state_e        state_r;
  logic [7:0]        cnt_r;
  logic              done_r;
  logic              ie_r;
  logic              go_r;
  logic              scan_r;
  logic              speed_r;
  logic [2:0]        chan_r;
  logic              armed_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;

  logic              csr_wr;
  logic              csr_rd;
  logic              go_kill;
  logic              conv_end;
  logic              fin;
  logic              last_ch;
  logic [7:0]        csr_byte;
  logic [7:0]        reg_byte;

  // ==========================================================
  // helpers
  function automatic logic [7:0] conv_len(input logic fast);
    conv_len = fast ? CONV_FAST_CYC : CONV_SLOW_CYC;
  endfunction

  function automatic logic [2:0] first_ch(input logic scan, input logic [2:0] chan);
    first_ch = scan ? {chan[CHAN_MSB], 2'b00} : chan;
  endfunction

  // ==========================================================
  // decode
  assign csr_wr   = reg_wr && (reg_addr == OFS_CSR);
  assign csr_rd   = reg_rd && (reg_addr == OFS_CSR);
  assign go_kill  = standby_req || (csr_wr && !reg_wdata[BIT_GO]);
  assign conv_end = (state_r == ST_CONV) && (cnt_r == 8'h01);
  assign fin      = conv_end && !go_kill;
  // a sweep pass ends on the channel whose low bits equal the count field
  assign last_ch  = scan_r ? (sar_channel_r[1:0] == chan_r[1:0]) : 1'b1;
  assign csr_byte = {done_r, ie_r, go_r, scan_r, speed_r, chan_r};

  always_comb begin
    reg_byte = 8'h00;
    unique case (reg_addr)
      OFS_CSR:      reg_byte = csr_byte;
      OFS_IRQ_STAT: reg_byte = {{(8-IRQ_W){1'b0}}, irq_stat_r};
      OFS_IRQ_MASK: reg_byte = {{(8-IRQ_W){1'b0}}, irq_mask_r};
      default:      reg_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // control fields
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ie_r    <= CSR_RESET[BIT_IE];
      scan_r  <= CSR_RESET[BIT_SCAN];
      speed_r <= CSR_RESET[BIT_SPEED];
      chan_r  <= CSR_RESET[2:0];
    end else if (csr_wr) begin
      // speed changes while running set the length from the next channel on; sar_fast_r follows one cycle after the write
      ie_r    <= reg_wdata[BIT_IE];
      scan_r  <= reg_wdata[BIT_SCAN];
      speed_r <= reg_wdata[BIT_SPEED];
      chan_r  <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      go_r <= CSR_RESET[BIT_GO];
    end else if (standby_req) begin
      go_r <= 1'b0;
    end else if (csr_wr) begin
      go_r <= reg_wdata[BIT_GO];
    end else if (fin && !scan_r) begin
      go_r <= 1'b0;
    end
  end

  // ==========================================================
  // end flag: a blind 0 write must not clear it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (csr_rd && done_r) begin
      armed_r <= 1'b1;
    end else if (csr_wr) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_r <= CSR_RESET[BIT_DONE];
    end else if (fin && last_ch) begin
      done_r <= 1'b1;
    end else if (csr_wr && armed_r && !reg_wdata[BIT_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r       <= ST_IDLE;
      cnt_r         <= 8'h00;
      sar_channel_r <= 3'h0;
      sar_busy_r    <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (go_r && !go_kill) begin
            state_r       <= ST_CONV;
            cnt_r         <= conv_len(speed_r);
            sar_channel_r <= first_ch(scan_r, chan_r);
            sar_busy_r    <= 1'b1;
          end
        end
        ST_CONV: begin
          if (go_kill || !go_r) begin
            state_r    <= ST_IDLE;
            sar_busy_r <= 1'b0;
          end else if (conv_end) begin
            if (!scan_r) begin
              state_r    <= ST_IDLE;
              sar_busy_r <= 1'b0;
            end else begin
              cnt_r <= conv_len(speed_r);
              if (last_ch) begin
                sar_channel_r <= first_ch(1'b1, chan_r);
              end else begin
                sar_channel_r <= sar_channel_r + 3'h1;
              end
            end
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sar_fast_r <= 1'b0;
    end else begin
      sar_fast_r <= speed_r;
    end
  end

  // ==========================================================
  // interrupt status and mask
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask_r <= IRQ_RESET;
    end else if (reg_wr && (reg_addr == OFS_IRQ_MASK)) begin
      irq_mask_r <= reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_r <= IRQ_RESET;
    end else begin
      // set wins over a simultaneous write-one clear
      irq_stat_r <= (irq_stat_r & ~((reg_wr && (reg_addr == OFS_IRQ_STAT)) ?
                      reg_wdata[IRQ_W-1:0] : IRQ_RESET))
                    | {fin, fin && last_ch};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conversion_end_irq_r <= 1'b0;
    end else begin
      conversion_end_irq_r <= (done_r && ie_r) || (|(irq_stat_r & irq_mask_r));
    end
  end

  // ==========================================================
  // result store
  acs_result_mem u_mem (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .wr_en     (fin),
    .wr_idx    (sar_channel_r[1:0]),
    .wr_data   ({sar_data, {RES_PAD{1'b0}}}),
    .rd_en     (reg_rd),
    .rd_addr   (reg_addr),
    .reg_byte  (reg_byte),
    .rd_data_r (reg_rdata)
  );

  // ==========================================================
  // checks
  a_single_go_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fin && !scan_r && !csr_wr |=> !go_r && !sar_busy_r)
    else $error("single conversion did not clear go");

  a_end_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fin && last_ch |=> done_r)
    else $error("end flag not set after conversion");

  a_flag_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(done_r) |-> $past(fin) && $past(last_ch))
    else $error("end flag set without a finished pass");

  a_flag_blind_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_r && !armed_r |=> done_r)
    else $error("end flag cleared without prior read");

  a_sweep_keeps_going: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fin && scan_r && !csr_wr |=> go_r && sar_busy_r)
    else $error("sweep stopped on its own");

  a_go_write_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    csr_wr && !reg_wdata[BIT_GO] |=> !go_r ##1 !sar_busy_r)
    else $error("clearing go did not stop conversion");

  a_go_starts_conv: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_IDLE && go_r && !go_kill |=> sar_busy_r)
    else $error("go did not start conversion");

  a_speed_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sar_busy_r) |-> cnt_r == ($past(speed_r) ? 8'h46 : 8'h86))
    else $error("conversion length wrong for speed");

  a_single_channel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sar_busy_r) && !$past(scan_r) |-> sar_channel_r == $past(chan_r))
    else $error("single mode converted wrong input");

  a_sweep_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fin && scan_r && !last_ch && !csr_wr |=> sar_channel_r == $past(sar_channel_r) + 3'h1)
    else $error("sweep did not step to the next input");

  a_sweep_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fin && scan_r && last_ch && !csr_wr |=> sar_channel_r == {$past(chan_r[2]), 2'b00})
    else $error("sweep did not restart at group start");

  a_standby_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    standby_req |=> !go_r ##1 !sar_busy_r)
    else $error("standby did not stop conversion");

  a_irq_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_r && ie_r |=> conversion_end_irq_r)
    else $error("end interrupt not raised");

  a_reset_clear: assert property (@(posedge ref_clk)
    !rst_n |=> csr_byte == 8'h00)
    else $error("control register not cleared by reset");

endmodule

// ==== acs_analog_model.sv ====
/*
  Behavioural model of the analog core behind the sequencer.
  Assumes the sequencer samples sar_data on the last cycle of a conversion.
*/
module acs_analog_model (
  // clock
  input  wire logic       ref_clk,
  // converter control
  input  wire logic [2:0] sar_channel_r,
  input  wire logic       sar_busy_r,
  // converted code
  output logic      [9:0] sar_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // code source
  logic [9:0] idle_q = 10'h155;

  // outside a conversion the code wanders, so a stray sample is caught
  always @(posedge ref_clk) begin
    idle_q <= idle_q + 10'h133;
  end

  // each input gives its own fixed code
  assign sar_data = sar_busy_r ? ({sar_channel_r, 7'h5A} ^ {7'h00, sar_channel_r}) : idle_q;
endmodule

// ==== tb_top.sv ====
/*
  Self-checking bench of the converter sequencer: register tasks and
  conversion scenarios. Assumes the analog model answers on the same clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;

  // ==========================================================
  // signals
  logic              ref_clk     = 1'b0;
  logic              rst_n       = 1'b0;
  logic              reg_wr      = 1'b0;
  logic              reg_rd      = 1'b0;
  logic              standby_req = 1'b0;
  logic [ADDR_W-1:0] reg_addr    = 4'h0;
  logic [DATA_W-1:0] reg_wdata   = 8'h00;
  logic [DATA_W-1:0] reg_rdata;
  logic [RES_W-1:0]  sar_data;
  logic [2:0]        sar_channel_r;
  logic              sar_busy_r;
  logic              sar_fast_r;
  logic              conversion_end_irq_r;
  logic [9:0]        cd;
  int                bad_count   = 0;
  int                checks      = 0;
  int                cyc         = 0;
  int                n;

  always #50 ref_clk = ~ref_clk;

  acs_sequencer dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sar_data(sar_data),
    .sar_channel_r(sar_channel_r), .sar_busy_r(sar_busy_r), .sar_fast_r(sar_fast_r),
    .standby_req(standby_req), .conversion_end_irq_r(conversion_end_irq_r)
  );

  acs_analog_model model_u (
    .ref_clk(ref_clk), .sar_channel_r(sar_channel_r), .sar_busy_r(sar_busy_r),
    .sar_data(sar_data)
  );

  // ==========================================================
  // helpers
  function automatic logic [9:0] code_of(input logic [2:0] c);
    return {c, 7'h5A} ^ {7'h00, c};
  endfunction

  task automatic results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 cmp(16'(reg_rdata), 16'(e));
  endtask

  task automatic busy_rise;
    #1 n = 0;
    while (sar_busy_r !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1 n++;
    end
    cmp(16'(sar_busy_r), 16'h0001);
  endtask

  task automatic busy_len(output int len);
    len = 0;
    while (sar_busy_r === 1'b1 && len < 300) begin
      @(posedge ref_clk);
      #1 len++;
    end
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 cmp(16'(conversion_end_irq_r), 16'(e));
  endtask

  // ==========================================================
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_CSR, CSR_RESET);
    rd(OFS_IRQ_STAT, 8'h00);
    rd(4'h0, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      cd = code_of(3'(c));
      wr(OFS_CSR, 8'h28 | 8'(c));
      busy_rise();
      cmp(16'(sar_channel_r), 16'(c));
      cmp(16'(sar_fast_r), 16'h0001);
      busy_len(n);
      cmp(16'(n), 16'(CONV_FAST_STATES));
      rd(OFS_CSR, 8'h88 | 8'(c));
      wr(OFS_CSR, 8'h08 | 8'(c));
      rd(OFS_CSR, 8'h08 | 8'(c));
      rd(4'(2 * (c % 4)), cd[9:2]);
    end
    rd(4'h7, {cd[1:0], 6'h00});
    $display("test single done");
    // go is already low before the speed changes
    wr(OFS_CSR, 8'h03);
    wr(OFS_CSR, 8'h23);
    busy_rise();
    cmp(16'(sar_fast_r), 16'h0000);
    busy_len(n);
    cmp(16'(n), 16'(CONV_SLOW_STATES));
    wr(OFS_CSR, 8'h03);
    rd(OFS_CSR, 8'h83);
    wr(OFS_CSR, 8'h03);
    rd(OFS_CSR, 8'h03);
    $display("test slow done");
    // input 1 leaves its code in word B, which the sweep must overwrite
    wr(OFS_CSR, 8'h69);
    busy_rise();
    busy_len(n);
    irq_is(1'b1);
    rd(OFS_CSR, 8'hC9);
    wr(OFS_CSR, 8'h49);
    irq_is(1'b0);
    wr(OFS_IRQ_MASK, 8'h01);
    irq_is(1'b1);
    wr(OFS_IRQ_STAT, 8'h01);
    irq_is(1'b0);
    rd(OFS_IRQ_STAT, 8'h02);
    rd(OFS_IRQ_MASK, 8'h01);
    wr(OFS_IRQ_MASK, 8'h00);
    $display("test irq done");
    wr(OFS_CSR, 8'h3D);
    busy_rise();
    cmp(16'(sar_channel_r), 16'h0004);
    repeat (70) @(posedge ref_clk);
    #1 cmp(16'(sar_channel_r), 16'h0005);
    repeat (70) @(posedge ref_clk);
    #1 cmp(16'(sar_channel_r), 16'h0004);
    rd(OFS_CSR, 8'hBD);
    cd = code_of(3'h5);
    rd(4'h2, cd[9:2]);
    wr(OFS_CSR, 8'h1D);
    repeat (3) @(posedge ref_clk);
    #1 cmp(16'(sar_busy_r), 16'h0000);
    rd(OFS_CSR, 8'h1D);
    $display("test scan done");
    wr(OFS_CSR, 8'h30);
    busy_rise();
    @(posedge ref_clk);
    standby_req <= 1'b1;
    @(posedge ref_clk);
    standby_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 cmp(16'(sar_busy_r), 16'h0000);
    rd(OFS_CSR, 8'h10);
    rd(4'hF, 8'h00);
    $display("test standby done");
    results();
  end
endmodule
